// *** cfc_config_fault_coder.v ***
`timescale 1ns/10ps
`default_nettype none
`include "cfc_defs.vh"
// Checks a submitted configuration and reports the first fault found
module cfc_config_fault_coder #(
  parameter FILT_W = 16
)
(
  input wire i_sys_clk,
  input wire i_nrst,
  input wire i_cfg_valid,
  input wire i_filter_bad,
  input wire i_sample_bad,
  input wire i_handle_bad,
  input wire [`CFC_NUM_CH*`CFC_NUM_CHK-1:0] i_ch_flags,
  input wire [`CFC_NUM_CH*FILT_W-1:0] i_ch_dig_filter,
  input wire [FILT_W-1:0] i_sample_period,
  output reg o_done,
  output reg o_accepted,
  output reg o_rejected,
  output reg [15:0] o_gen_status,
  output reg [15:0] o_ext_code
);
  reg rst_meta_ff;
  reg rst_sync_ff;
  wire rst_n;
  wire [`CFC_NUM_CH-1:0] ch_fail;
  wire [`CFC_NUM_CH*`CFC_CHK_W-1:0] ch_ofs;
  reg [15:0] nxt_code;
  reg nxt_bad;
  integer c;
  genvar g;

  // Reset asserts at once, releases through two flops to avoid metastable release
  always @(posedge i_sys_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  // One checker per channel
  generate
    for (g = 0; g < `CFC_NUM_CH; g = g + 1)
    begin : g_ch
      cfc_chan_check #(
        .FILT_W(FILT_W)
      ) u_chk (
        .i_flags(i_ch_flags[g*`CFC_NUM_CHK +: `CFC_NUM_CHK]),
        .i_dig_filter(i_ch_dig_filter[g*FILT_W +: FILT_W]),
        .i_sample_period(i_sample_period),
        .o_fail(ch_fail[g]),
        .o_ofs(ch_ofs[g*`CFC_CHK_W +: `CFC_CHK_W])
      );
    end
  endgenerate

  // Priority encode: module-wide first, then lowest channel
  always @*
  begin
    nxt_bad = 1'b1;
    nxt_code = `CFC_CODE_NONE;
    if (i_filter_bad)
    begin
      nxt_code = `CFC_CODE_FILTER;
    end
    else if (i_sample_bad)
    begin
      nxt_code = `CFC_CODE_SAMPLE;
    end
    else if (i_handle_bad)
    begin
      nxt_code = `CFC_CODE_HANDLE;
    end
    else
    begin
      nxt_bad = |ch_fail;
      for (c = `CFC_NUM_CH - 1; c >= 0; c = c - 1)
      begin
        if (ch_fail[c])
        begin
          // Base 0x0005 plus sixteen per channel plus the check offset
          nxt_code = `CFC_CH_BASE0 + (c[15:0] << 4)
            + {12'h000, ch_ofs[c*`CFC_CHK_W +: `CFC_CHK_W]};
        end
      end
    end
  end

  // Result registered on each request and held until the next one
  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_done <= 1'b0;
      o_accepted <= 1'b0;
      o_rejected <= 1'b0;
      o_gen_status <= `CFC_STAT_OK;
      o_ext_code <= `CFC_CODE_NONE;
    end
    else
    begin
      o_done <= i_cfg_valid;
      if (i_cfg_valid)
      begin
        o_accepted <= ~nxt_bad;
        o_rejected <= nxt_bad;
        o_gen_status <= nxt_bad ? `CFC_STAT_PARAM_ERR : `CFC_STAT_OK;
        o_ext_code <= nxt_bad ? nxt_code : `CFC_CODE_NONE;
      end
    end
  end
endmodule // cfc_config_fault_coder
`default_nettype wire

// *** cfc_defs.vh ***
// Contract
// - A configuration with any unacceptable parameter is rejected with general status 0x0009 and an extended code naming the error.
// - Module-wide errors report 0x0002 for a bad filter, 0x0003 for a bad sample period and 0x0004 for a bad handling time.
// - Each channel owns a block of codes starting at 0x0005 plus sixteen per channel, whose first code flags a process alarm latch left enabled.
// - Base plus one flags a rate alarm latch left enabled, plus two a bad input range, plus four a bad rate alarm setting.
// - Base plus three flags a digital filter longer than twice the sample period.
// - Base plus six flags low signal limit at or above high limit, base plus five a signal out of range.
// - Base plus eight flags equal high and low engineering values, base plus seven a calibration bias that is not a number.
// - Base plus nine flags a bad digital communication rate.
// - Base plus ten flags a bad high or low alarm, eleven a bad low-low, twelve a bad high-high limit.
// - Base plus thirteen flags a bad alarm deadband.
`ifndef CFC_DEFS_VH
`define CFC_DEFS_VH
`define CFC_STAT_OK 16'h0000
`define CFC_STAT_PARAM_ERR 16'h0009
`define CFC_CODE_NONE 16'h0000
`define CFC_CODE_FILTER 16'h0002
`define CFC_CODE_SAMPLE 16'h0003
`define CFC_CODE_HANDLE 16'h0004
`define CFC_CH_BASE0 16'h0005
`define CFC_CH_STRIDE 16'h0010
`define CFC_NUM_CH 8
`define CFC_NUM_CHK 14
`define CFC_CHK_W 4
// Check offsets inside a channel block
`define CFC_OFS_PA_LATCH 0
`define CFC_OFS_RA_LATCH 1
`define CFC_OFS_RANGE 2
`define CFC_OFS_FILT2X 3
`define CFC_OFS_RATE_ALM 4
`define CFC_OFS_SIG_OOR 5
`define CFC_OFS_LO_GE_HI 6
`define CFC_OFS_BIAS_NAN 7
`define CFC_OFS_ENG_EQ 8
`define CFC_OFS_COMM_RATE 9
`define CFC_OFS_HL_ALM 10
`define CFC_OFS_LL_ALM 11
`define CFC_OFS_HH_ALM 12
`define CFC_OFS_DEADBAND 13
// Pipeline states
`define CFC_ST_IDLE 2'h0
`define CFC_ST_EVAL 2'h1
`define CFC_ST_DONE 2'h2
`endif

// *** cfc_chan_check.v ***
`timescale 1ns/10ps
`default_nettype none
`include "cfc_defs.vh"
// One channel: folds per-channel fault flags into the lowest failing offset
module cfc_chan_check #(
  parameter FILT_W = 16
)
(
  input wire [`CFC_NUM_CHK-1:0] i_flags,
  input wire [FILT_W-1:0] i_dig_filter,
  input wire [FILT_W-1:0] i_sample_period,
  output reg o_fail,
  output reg [`CFC_CHK_W-1:0] o_ofs
);
  reg [`CFC_NUM_CHK-1:0] all_flags;
  reg filt_over;
  integer k;
  // Filter compared with twice the period; one extra bit keeps the doubling exact
  always @*
  begin
    filt_over = ({1'b0, i_dig_filter} > {i_sample_period, 1'b0});
    all_flags = i_flags;
    all_flags[`CFC_OFS_FILT2X] = i_flags[`CFC_OFS_FILT2X] | filt_over;
    o_fail = |all_flags;
    o_ofs = {`CFC_CHK_W{1'b0}};
    // Descending scan so the lowest offset wins
    for (k = `CFC_NUM_CHK - 1; k >= 0; k = k - 1)
    begin
      if (all_flags[k])
      begin
        o_ofs = k[`CFC_CHK_W-1:0];
      end
    end
  end
endmodule // cfc_chan_check
`default_nettype wire

// *** cfc_monitor.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "cfc_defs.vh"
// Ties each verdict to the request one cycle before it
module cfc_monitor (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_cfg_valid,
  input wire logic i_filter_bad,
  input wire logic i_sample_bad,
  input wire logic i_handle_bad,
  input wire logic [`CFC_NUM_CH*`CFC_NUM_CHK-1:0] i_ch_flags,
  input wire logic o_done,
  input wire logic o_accepted,
  input wire logic o_rejected,
  input wire logic [15:0] o_gen_status,
  input wire logic [15:0] o_ext_code
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  // Request with no module-wide fault, so channel codes may win
  sequence s_ok; i_cfg_valid && !i_filter_bad && !i_sample_bad && !i_handle_bad; endsequence
  property p_done; i_cfg_valid |=> o_done && (o_accepted ^ o_rejected); endproperty
  a_done: assert property (p_done) else $error("no single verdict");
  property p_idle; !i_cfg_valid |=> !o_done && $stable(o_ext_code); endproperty
  a_idle: assert property (p_idle) else $error("code moved idle");
  property p_rej; o_done && o_rejected |-> o_gen_status == 16'h0009 && o_ext_code != 0; endproperty
  a_rej: assert property (p_rej) else $error("bad reject");
  property p_acc; o_done && o_accepted |-> o_gen_status == 0 && o_ext_code == 0; endproperty
  a_acc: assert property (p_acc) else $error("bad accept");
  property p_flt; i_cfg_valid && i_filter_bad |=> o_ext_code == 16'h0002; endproperty
  a_flt: assert property (p_flt) else $error("bad filter code");
  property p_smp; i_cfg_valid && !i_filter_bad && i_sample_bad |=> o_ext_code == 16'h0003; endproperty
  a_smp: assert property (p_smp) else $error("bad period code");
  property p_ch0; s_ok ##0 i_ch_flags[0] |=> o_ext_code == 16'h0005; endproperty
  a_ch0: assert property (p_ch0) else $error("bad base code");
  property p_rng; s_ok ##0 i_ch_flags[2:0] == 3'h4 |=> o_ext_code == 16'h0007; endproperty
  a_rng: assert property (p_rng) else $error("bad range code");
endmodule // cfc_monitor
bind cfc_config_fault_coder cfc_monitor i_mon (.*);
`default_nettype wire

// *** cfc_ctrl_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Controller: builds a config holding up to two faults, by code
module cfc_ctrl_model (
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [15:0] i_code_a,
  input wire logic [15:0] i_code_b,
  output logic o_valid,
  output logic [2:0] o_mod_bad,
  output logic [111:0] o_flags,
  output logic [127:0] o_filter
);
  initial {o_valid, o_mod_bad, o_flags, o_filter} = '0;
  // Idle cycles invert the config so a stale answer cannot hide
  always @(posedge i_clk)
  begin : p_send
    logic [15:0] c;
    logic [2:0] m;
    logic [111:0] f;
    logic [127:0] d;
    {m, f, d} = {115'h0, {8{16'h0020}}};
    for (int k = 0; k < 2; k++)
    begin
      c = k ? i_code_b : i_code_a;
      if (c > 4 && ((c - 5) & 15) == 3)
        d[((c - 5) >> 4) * 16 +: 16] = 16'h0021;
      else if (c > 4)
        f[((c - 5) >> 4) * 14 + ((c - 5) & 15)] = 1'b1;
      else if (c > 1)
        m[4 - c] = 1'b1;
    end
    o_valid <= i_go;
    {o_mod_bad, o_flags, o_filter} <= i_go ? {m, f, d} : ~{o_mod_bad, o_flags, o_filter};
  end
endmodule // cfc_ctrl_model
`default_nettype wire

// *** test_config_fault_coder.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_config_fault_coder;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic [15:0] a = 16'h0000, b = 16'h0000, c, gs, ec;
  logic v, done, acc, rej;
  logic [2:0] mb;
  logic [111:0] fl;
  logic [127:0] df;
  int mismatches = 0, total_checks = 0;
  logic [47:0] rows [0:4] = '{48'h0, 48'h0004_0003_0003, 48'h0004_0005_0004,
    48'h0082_0075_0075, 48'h0012_0008_0008};
  // 20 MHz clock
  always #25 clk = ~clk;
  cfc_ctrl_model i_ctrl (.i_clk(clk), .i_go(go), .i_code_a(a), .i_code_b(b),
    .o_valid(v), .o_mod_bad(mb), .o_flags(fl), .o_filter(df));
  cfc_config_fault_coder i_dut (.i_sys_clk(clk), .i_nrst(nrst), .i_cfg_valid(v),
    .i_filter_bad(mb[2]), .i_sample_bad(mb[1]), .i_handle_bad(mb[0]), .i_ch_flags(fl),
    .i_ch_dig_filter(df), .i_sample_period(16'h0010), .o_done(done), .o_accepted(acc),
    .o_rejected(rej), .o_gen_status(gs), .o_ext_code(ec));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // One request, answer checked, then held through a scrambled idle cycle
  task automatic run(input logic [15:0] x, input logic [15:0] y, input logic [15:0] e);
    int n = 0;
    @(posedge clk) {a, b, go} <= {x, y, 1'b1};
    @(posedge clk) go <= 1'b0;
    while (done !== 1'b1)
    begin
      @(posedge clk) #1;
      if (++n > 3)
      begin
        mismatches++;
        complete_run();
      end
    end
    chk(ec, e);
    chk(gs, e ? 16'h0009 : 16'h0000);
    chk({14'h0, acc, rej}, e ? 16'h0001 : 16'h0002);
    @(posedge clk) #1 chk({15'h0000, done}, 16'h0000);
    chk(ec, e);
  endtask
  task automatic do_reset;
    @(posedge clk) nrst <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(ec | gs, 16'h0000);
    @(posedge clk) nrst <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  initial
  begin
    do_reset();
    foreach (rows[i]) run(rows[i][47:32], rows[i][31:16], rows[i][15:0]);
    $display("rows done");
    for (int ch = 0; ch < 8; ch++)
      for (int o = 0; o < 14; o++)
      begin
        c = 16'h0005 + 16'(ch * 16 + o);
        run(c, 16'h0000, c);
      end
    $display("sweep done");
    do_reset();
    run(16'h0002, 16'h0011, 16'h0002);
    $display("reset done");
    complete_run();
  end
endmodule // test_config_fault_coder
`default_nettype wire
